// ---- common/fault_pkg.sv ----
// Contract
// - keep requesting power lowering while a lowering fault persists
// - lowering fault from repeated reflected trips or over-temperature input
// - reflected-power lowering latches its indicator until reset
// - temperature lowering latches the over-temperature indicator
// - single reflected trip kills amplifiers for a 14 to 19 ms window
// - each reflected trip gives a 0.5 s momentary local and remote indication
// - remote power-lowered status while lowering has reduced power
// - kill class asserts amplifier kill, supply stays energized
// - kill class indication shows only while the condition is present
// - conversion error clears modulator data and sets its indicator
// - blown-fuse shown only with supply energized and a fuse open
// - blown-fuse indication not latched, no effect on operation
// - classes one to four OR their sources and drive actions
// - any shutdown-class input drives combined shutdown fault high
// - shutdown fault also asserts when recycle fault recurs at restart
// - shutdown fault stretched to at least 1 s or while present
// - detection outputs follow the fault, indications latch until reset except kill, blown-fuse and momentary reflected
// - recycle fault present at restart or within 2.4 s becomes shutdown
// - shutdown class fed by interlocks, supply, cable and regulator faults
// - recycle class fed by drive low, drive high, supply overload
// - kill class fed by single reflected trip and converter regulator faults
// - recycle fault removes supply about 1 s then requests turn-on
// - after shutdown the transmitter stays off until operator turn-on
// - reset clears latches, delayed phase re-latches present faults
package fault_pkg;
  localparam int CLK_MHZ = 100;
  localparam int KILL_MS = 14;
  localparam int MOMENT_MS = 500;
  localparam int STRETCH_MS = 1000;
  localparam int RECYCLE_MS = 1000;
  localparam int REPEAT_MS = 2400;
  localparam int BURST_MS = 100;
  localparam int BURST_HITS = 2;
  localparam int KILL_CYC = KILL_MS * CLK_MHZ * 1000;
  localparam int MOMENT_CYC = MOMENT_MS * CLK_MHZ * 1000;
  localparam int STRETCH_CYC = STRETCH_MS * CLK_MHZ * 1000;
  localparam int RECYCLE_CYC = RECYCLE_MS * CLK_MHZ * 1000;
  localparam int REPEAT_CYC = REPEAT_MS * CLK_MHZ * 1000;
  localparam int BURST_CYC = BURST_MS * CLK_MHZ * 1000;
  localparam int CNT_W = 28;
  localparam int SD_W = 10;
  localparam int RC_W = 3;
  localparam int KL_W = 5;
  typedef struct packed {
    logic ext_interlock;
    logic airflow;
    logic door;
    logic supply_prot;
    logic overvolt;
    logic enc_cable;
    logic reg_bplus;
    logic reg_bminus;
    logic mon_reg_5v;
    logic mon_reg_15v;
  } shutdown_src_t;
  typedef struct packed {
    logic drive_low;
    logic drive_high;
    logic supply_ovl;
  } recycle_src_t;
  typedef struct packed {
    logic adc_p15;
    logic adc_m15;
    logic adc_p5;
    logic ain_p14;
    logic ain_m15;
  } kill_src_t;
  typedef enum logic [1:0] {
    RC_RUN = 2'b00,
    RC_OFF = 2'b01,
    RC_WATCH = 2'b11,
    RC_SPARE = 2'b10
  } recycle_state_t;
endpackage

// ---- hw/sync2.sv ----
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;
  // two flops; only the second stage is seen outside
  always_comb begin
    meta_d = i_async;
    sync_d = meta_q;
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end
  assign o_sync = sync_q;
endmodule

// ---- hw/interval_timer.sv ----
`timescale 1ns/1ns
module interval_timer #(
  parameter logic [27:0] LEN = 28'h0000001
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_start,
  output logic o_busy
);
  logic [27:0] cnt_q;
  logic [27:0] cnt_d;
  // start reloads; counts down to zero, busy while nonzero
  always_comb begin
    if (i_start) begin
      cnt_d = LEN;
    end else if (cnt_q != 28'h0000000) begin
      cnt_d = cnt_q - 28'h0000001;
    end else begin
      cnt_d = cnt_q;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      cnt_q <= 28'h0000000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign o_busy = (cnt_q != 28'h0000000);
endmodule

// ---- hw/fault_manager.sv ----
`timescale 1ns/1ns
module fault_manager #(
  parameter int KILL_CYC = fault_pkg::KILL_CYC,
  parameter int MOMENT_CYC = fault_pkg::MOMENT_CYC,
  parameter int STRETCH_CYC = fault_pkg::STRETCH_CYC,
  parameter int RECYCLE_CYC = fault_pkg::RECYCLE_CYC,
  parameter int REPEAT_CYC = fault_pkg::REPEAT_CYC,
  parameter int BURST_CYC = fault_pkg::BURST_CYC
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // detector sense inputs, asynchronous
  input wire fault_pkg::shutdown_src_t i_shutdown_src,
  input wire fault_pkg::recycle_src_t i_recycle_src,
  input wire fault_pkg::kill_src_t i_kill_src,
  input wire logic i_refl_trip,
  input wire logic i_over_temp,
  input wire logic i_conv_error,
  input wire logic i_fuse_open,
  input wire logic i_supply_on,
  // operator controls, asynchronous
  input wire logic i_local_reset,
  input wire logic i_remote_reset,
  input wire logic i_turn_on_cmd,
  // action outputs
  output logic o_shutdown_fault,
  output logic o_supply_enable,
  output logic o_turn_on_req,
  output logic o_lower_req,
  output logic o_amplifier_kill,
  output logic o_data_clear,
  // indications
  output logic o_ind_shutdown,
  output logic o_ind_recycle,
  output logic o_ind_refl_lower,
  output logic o_ind_over_temp,
  output logic o_ind_refl_moment,
  output logic o_remote_refl,
  output logic o_remote_lowered,
  output logic o_ind_kill,
  output logic o_ind_conv_error,
  output logic o_ind_fuse
);
  localparam int NS = fault_pkg::SD_W + fault_pkg::RC_W + fault_pkg::KL_W + 8;

  // every sense input through two flops first
  logic [NS-1:0] raw_w;
  logic [NS-1:0] syn_w;
  assign raw_w = {i_shutdown_src, i_recycle_src, i_kill_src, i_refl_trip, i_over_temp,
                  i_conv_error, i_fuse_open, i_supply_on, i_local_reset, i_remote_reset,
                  i_turn_on_cmd};
  sync2 #(.W(NS)) u_sync (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_async(raw_w),
    .o_sync(syn_w)
  );

  logic [fault_pkg::SD_W-1:0] sd_s;
  logic [fault_pkg::RC_W-1:0] rc_s;
  logic [fault_pkg::KL_W-1:0] kl_s;
  logic refl_s, temp_s, conv_s, fuse_s, supply_s, lrst_s, rrst_s, on_s;
  assign {sd_s, rc_s, kl_s, refl_s, temp_s, conv_s, fuse_s, supply_s, lrst_s, rrst_s,
          on_s} = syn_w;

  // class OR functions
  logic sd_any, rc_any, kl_any, rst_any;
  assign sd_any = |sd_s;
  assign rc_any = |rc_s;
  assign kl_any = |kl_s;
  assign rst_any = lrst_s | rrst_s;

  // reflected trip edge and burst detection
  logic refl_prev_q, refl_prev_d;
  logic [1:0] hits_q, hits_d;
  logic refl_lower_q, refl_lower_d;
  logic refl_edge, burst_busy;
  assign refl_edge = refl_s & ~refl_prev_q;
  // a second hit inside the burst window means sustained reflection, not a transient
  always_comb begin
    refl_prev_d = refl_s;
    hits_d = hits_q;
    if (!burst_busy && !refl_edge) begin
      hits_d = 2'h0;
    end else if (refl_edge && hits_q != 2'h3) begin
      hits_d = hits_q + 2'h1;
    end
    refl_lower_d = (hits_d >= 2'(fault_pkg::BURST_HITS));
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      refl_prev_q <= 1'b0;
      hits_q <= 2'h0;
      refl_lower_q <= 1'b0;
    end else begin
      refl_prev_q <= refl_prev_d;
      hits_q <= hits_d;
      refl_lower_q <= refl_lower_d;
    end
  end

  // timers: burst window, kill window, momentary indication, stretch, recycle, repeat
  logic kill_busy, moment_busy, stretch_busy, off_busy, repeat_busy;
  logic sd_cause, rc_start, restart_pulse;
  interval_timer #(.LEN(28'(BURST_CYC))) u_burst (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(refl_edge), .o_busy(burst_busy));
  interval_timer #(.LEN(28'(KILL_CYC))) u_kill (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(refl_edge), .o_busy(kill_busy));
  interval_timer #(.LEN(28'(MOMENT_CYC))) u_moment (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(refl_edge), .o_busy(moment_busy));
  interval_timer #(.LEN(28'(STRETCH_CYC))) u_stretch (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(sd_cause), .o_busy(stretch_busy));
  interval_timer #(.LEN(28'(RECYCLE_CYC))) u_off (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(rc_start), .o_busy(off_busy));
  interval_timer #(.LEN(28'(REPEAT_CYC))) u_repeat (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_start(restart_pulse), .o_busy(repeat_busy));

  // recycle sequencer: off about 1 s, restart, then watch for a repeat
  fault_pkg::recycle_state_t rc_q, rc_d;
  logic promote;
  always_comb begin
    rc_d = rc_q;
    rc_start = 1'b0;
    restart_pulse = 1'b0;
    promote = 1'b0;
    case (rc_q)
      fault_pkg::RC_RUN: begin
        if (rc_any && o_supply_enable) begin
          rc_d = fault_pkg::RC_OFF;
          rc_start = 1'b1;
        end
      end
      fault_pkg::RC_OFF: begin
        if (sd_cause) begin
          rc_d = fault_pkg::RC_RUN;
        end else if (!off_busy && !rc_start) begin
          rc_d = fault_pkg::RC_WATCH;
          restart_pulse = 1'b1;
        end
      end
      fault_pkg::RC_WATCH: begin
        // present at restart or recurring inside the watch window
        if (rc_any && (repeat_busy || restart_pulse)) begin
          promote = 1'b1;
          rc_d = fault_pkg::RC_RUN;
        end else if (!repeat_busy) begin
          rc_d = fault_pkg::RC_RUN;
        end
      end
      default: rc_d = fault_pkg::RC_RUN;
    endcase
  end
  assign sd_cause = sd_any | promote;

  // supply run state: off after shutdown until operator turn-on
  logic run_q, run_d;
  logic sd_out_q, sd_out_d;
  logic on_req_q, on_req_d;
  always_comb begin
    sd_out_d = sd_cause | stretch_busy;
    run_d = run_q;
    on_req_d = 1'b0;
    if (sd_out_d) begin
      run_d = 1'b0;
    end else if (on_s && !run_q) begin
      run_d = 1'b1;
      on_req_d = 1'b1;
    end else if (rc_q == fault_pkg::RC_OFF && !off_busy && !rc_start) begin
      on_req_d = 1'b1;
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rc_q <= fault_pkg::RC_RUN;
      run_q <= 1'b0;
      sd_out_q <= 1'b0;
      on_req_q <= 1'b0;
    end else begin
      rc_q <= rc_d;
      run_q <= run_d;
      sd_out_q <= sd_out_d;
      on_req_q <= on_req_d;
    end
  end

  // reset phases: phase a clears, phase b one cycle later re-latches
  logic rst_a_q, rst_a_d, rst_b_q, rst_b_d;
  logic [5:0] cause;
  logic [5:0] lat_q, lat_d;
  assign cause = {sd_cause, rc_start, refl_lower_q, temp_s, conv_s, 1'b0};
  always_comb begin
    rst_a_d = rst_any;
    rst_b_d = rst_a_q;
    lat_d = lat_q | cause; // set wins over any clear
    if (rst_a_q) begin
      lat_d = cause;
    end else if (rst_b_q) begin
      // fault still present at release is latched again
      lat_d = lat_q | cause | {sd_any, rc_any, refl_lower_q, temp_s, conv_s, 1'b0};
    end
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rst_a_q <= 1'b0;
      rst_b_q <= 1'b0;
      lat_q <= 6'h00;
    end else begin
      rst_a_q <= rst_a_d;
      rst_b_q <= rst_b_d;
      lat_q <= lat_d;
    end
  end

  // registered action and indication outputs
  logic lower_q, lower_d, kill_q, kill_d, clr_q, clr_d, fuse_q, fuse_d;
  logic ind_kill_q, ind_kill_d, mom_q, mom_d, sup_q, sup_d;
  always_comb begin
    lower_d = refl_lower_q | temp_s;
    kill_d = kl_any | (kill_busy & ~refl_lower_q);
    ind_kill_d = kl_any | kill_busy;
    clr_d = conv_s;
    fuse_d = supply_s & fuse_s;
    mom_d = moment_busy;
    sup_d = run_d & (rc_d != fault_pkg::RC_OFF);
  end
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      lower_q <= 1'b0;
      kill_q <= 1'b0;
      ind_kill_q <= 1'b0;
      clr_q <= 1'b0;
      fuse_q <= 1'b0;
      mom_q <= 1'b0;
      sup_q <= 1'b0;
    end else begin
      lower_q <= lower_d;
      kill_q <= kill_d;
      ind_kill_q <= ind_kill_d;
      clr_q <= clr_d;
      fuse_q <= fuse_d;
      mom_q <= mom_d;
      sup_q <= sup_d;
    end
  end

  assign o_shutdown_fault = sd_out_q;
  assign o_supply_enable = sup_q;
  assign o_turn_on_req = on_req_q;
  assign o_lower_req = lower_q;
  assign o_amplifier_kill = kill_q;
  assign o_data_clear = clr_q;
  assign o_ind_shutdown = lat_q[5];
  assign o_ind_recycle = lat_q[4];
  assign o_ind_refl_lower = lat_q[3];
  assign o_ind_over_temp = lat_q[2];
  assign o_ind_conv_error = lat_q[1]; // latch bit holds the error until reset, no output gate
  assign o_ind_refl_moment = mom_q;
  assign o_remote_refl = mom_q;
  assign o_remote_lowered = lower_q;
  assign o_ind_kill = ind_kill_q;
  assign o_ind_fuse = fuse_q;
endmodule

// ---- dv/ctrl_model.sv ----
`timescale 1ns/1ns
module ctrl_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // from the fault block
  input wire logic i_supply_enable,
  input wire logic i_turn_on_req,
  // back to the fault block and the bench
  output logic o_supply_on,
  output int o_ons
);
  // contactor feedback one cycle late, a real one is far slower
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_supply_on <= 1'b0;
      o_ons <= 0;
    end else begin
      o_supply_on <= i_supply_enable;
      o_ons <= o_ons + (i_turn_on_req ? 1 : 0);
    end
  end
endmodule

// ---- dv/fault_manager_chk.sv ----
`timescale 1ns/1ns
module fault_manager_chk #(
  parameter int KILL_CYC = 20,
  parameter int MOMENT_CYC = 40,
  parameter int STRETCH_CYC = 30
) (
  input wire logic i_mclk, i_rstn, i_over_temp, i_conv_error, i_fuse_open, i_supply_on,
  input wire logic i_local_reset, i_remote_reset, o_shutdown_fault, o_supply_enable,
  input wire logic o_lower_req, o_amplifier_kill, o_data_clear, o_ind_over_temp,
  input wire logic o_ind_refl_lower, o_ind_refl_moment, o_remote_refl, o_remote_lowered,
  input wire logic o_ind_kill, o_ind_conv_error, o_ind_fuse,
  input wire fault_pkg::shutdown_src_t i_shutdown_src,
  input wire fault_pkg::kill_src_t i_kill_src
);
  int sd_q;
  int kl_q;
  int mo_q;
  int ks_q;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  // run lengths of the timed outputs, judged at the cycle they fall
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      sd_q <= 0;
      kl_q <= 0;
      mo_q <= 0;
      ks_q <= 8;
    end else begin
      sd_q <= o_shutdown_fault ? sd_q + 1 : 0;
      kl_q <= o_amplifier_kill ? kl_q + 1 : 0;
      mo_q <= o_ind_refl_moment ? mo_q + 1 : 0;
      // cycles since a kill source was seen, saturating; a source-driven kill is not windowed
      ks_q <= (|i_kill_src) ? 0 : ((ks_q < 8) ? ks_q + 1 : ks_q);
    end
  end
  AST_SD_SRC: assert property ((|i_shutdown_src)[*6] |-> o_shutdown_fault)
    else $error("shutdown source not reported");
  AST_SD_STRETCH: assert property ($fell(o_shutdown_fault) |-> sd_q >= STRETCH_CYC - 1)
    else $error("shutdown fault too short");
  // a burst of trips lowers power instead, which cuts the kill short on purpose
  AST_KILL_WIN: assert property ($fell(o_amplifier_kill) && !o_lower_req && ks_q == 8
    |-> kl_q >= KILL_CYC - 1)
    else $error("kill window too short");
  AST_KILL_SRC: assert property ((|i_kill_src)[*6] |-> o_amplifier_kill && o_ind_kill
    && $stable(o_supply_enable))
    else $error("kill source not acted on");
  AST_MOMENT: assert property ($fell(o_ind_refl_moment)
    |-> mo_q >= MOMENT_CYC - 1 && !o_remote_refl)
    else $error("momentary reflected indication too short or remote differs");
  AST_LOWERED: assert property ($rose(o_ind_refl_lower) |-> o_remote_lowered)
    else $error("reflected lowering without remote lowered status");
  AST_TEMP: assert property (i_over_temp[*6] |-> o_lower_req && o_ind_over_temp)
    else $error("over temperature did not lower power");
  AST_LATCH: assert property ((!i_local_reset && !i_remote_reset)[*5] ##0 o_ind_refl_lower
    |=> o_ind_refl_lower)
    else $error("reflected lowering indication dropped without reset");
  AST_CONV: assert property (i_conv_error[*6] |-> o_data_clear && o_ind_conv_error)
    else $error("conversion error not acted on");
  AST_FUSE: assert property ((!(i_supply_on && i_fuse_open))[*6] |-> !o_ind_fuse)
    else $error("fuse indication without cause");
  COV_LOWER: cover property ($rose(o_lower_req));
  COV_KILL: cover property ($fell(o_amplifier_kill));
  COV_SD: cover property ($fell(o_shutdown_fault));
endmodule
bind fault_manager fault_manager_chk #(.KILL_CYC(KILL_CYC), .MOMENT_CYC(MOMENT_CYC),
  .STRETCH_CYC(STRETCH_CYC)) u_chk (.*);

// ---- dv/fault_manager_tb_top.sv ----
`timescale 1ns/1ns
module fault_manager_tb_top;
  localparam int KC = 20;
  localparam int MC = 40;
  localparam int SC = 30;
  localparam int RC = 20;
  localparam int PC = 60;
  localparam int BC = 30;
  logic i_mclk, i_rstn, i_refl_trip, i_over_temp, i_conv_error, i_fuse_open, i_supply_on;
  logic i_local_reset, i_remote_reset, i_turn_on_cmd;
  fault_pkg::shutdown_src_t i_shutdown_src;
  fault_pkg::recycle_src_t i_recycle_src;
  fault_pkg::kill_src_t i_kill_src;
  logic o_shutdown_fault, o_supply_enable, o_turn_on_req, o_lower_req, o_amplifier_kill;
  logic o_data_clear, o_ind_shutdown, o_ind_recycle, o_ind_refl_lower, o_ind_over_temp;
  logic o_ind_refl_moment, o_remote_refl, o_remote_lowered, o_ind_kill, o_ind_conv_error;
  logic o_ind_fuse;
  int errors, tests_run, cycles, ons;
  // shortened intervals keep the run under a thousand cycles long
  fault_manager #(.KILL_CYC(KC), .MOMENT_CYC(MC), .STRETCH_CYC(SC), .RECYCLE_CYC(RC),
    .REPEAT_CYC(PC), .BURST_CYC(BC)) u_dut (.*);
  ctrl_model u_ctrl (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_supply_enable(o_supply_enable),
    .i_turn_on_req(o_turn_on_req), .o_supply_on(i_supply_on), .o_ons(ons));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // held three cycles so both synchroniser flops see it
  task automatic ind_rst(input logic remote);
    if (remote) i_remote_reset = 1'b1;
    else i_local_reset = 1'b1;
    cyc(3);
    i_remote_reset = 1'b0;
    i_local_reset = 1'b0;
    cyc(6);
  endtask
  task automatic power_on();
    i_turn_on_cmd = 1'b1;
    cyc(3);
    i_turn_on_cmd = 1'b0;
    cyc(6);
  endtask
  task automatic hit();
    i_refl_trip = 1'b1;
    cyc(3);
    i_refl_trip = 1'b0;
    cyc(3);
  endtask
  task automatic t_shutdown();
    for (int i = 0; i < 10; i++) begin
      i_shutdown_src = fault_pkg::shutdown_src_t'(10'h001 << i);
      cyc(6);
      chk(o_shutdown_fault, 1'b1);
    end
    power_on();
    chk(o_supply_enable, 1'b0);
    i_shutdown_src = '0;
    cyc(SC - 8);
    chk(o_shutdown_fault, 1'b1);
    cyc(16);
    chk({o_shutdown_fault, o_supply_enable, o_ind_shutdown}, 3'h1);
    ind_rst(1'b0);
    chk(o_ind_shutdown, 1'b0);
    power_on();
    chk(o_supply_enable, 1'b1);
    $display("test shutdown done");
  endtask
  task automatic t_kill();
    for (int k = 0; k < 5; k++) begin
      i_kill_src = fault_pkg::kill_src_t'(5'h01 << k);
      cyc(KC);
      chk({o_amplifier_kill, o_ind_kill, o_supply_enable}, 3'h7);
      i_kill_src = '0;
      cyc(KC + 6);
      chk({o_amplifier_kill, o_ind_kill}, 2'h0);
    end
    i_conv_error = 1'b1;
    cyc(KC);
    chk({o_data_clear, o_ind_conv_error}, 2'h3);
    i_conv_error = 1'b0;
    i_fuse_open = 1'b1;
    cyc(KC + 6);
    chk({o_ind_fuse, o_supply_enable, o_data_clear}, 3'h6);
    i_fuse_open = 1'b0;
    cyc(6);
    chk(o_ind_fuse, 1'b0);
    $display("test kill done");
  endtask
  task automatic t_refl();
    hit();
    chk({o_amplifier_kill, o_ind_refl_moment, o_remote_refl, o_lower_req}, 4'he);
    cyc(KC - 12);
    chk(o_amplifier_kill, 1'b1);
    cyc(12);
    chk({o_amplifier_kill, o_ind_refl_moment}, 2'h1);
    cyc(MC);
    chk({o_ind_refl_moment, o_remote_refl, o_ind_refl_lower}, 3'h0);
    hit();
    hit();
    chk({o_lower_req, o_remote_lowered, o_ind_refl_lower}, 3'h7);
    cyc(BC + MC);
    chk({o_lower_req, o_ind_refl_lower}, 2'h1);
    ind_rst(1'b1);
    chk(o_ind_refl_lower, 1'b0);
    i_over_temp = 1'b1;
    cyc(6);
    chk({o_lower_req, o_remote_lowered, o_ind_over_temp}, 3'h7);
    ind_rst(1'b0);
    chk(o_ind_over_temp, 1'b1);
    i_over_temp = 1'b0;
    cyc(6);
    chk({o_lower_req, o_ind_over_temp}, 2'h1);
    $display("test lower done");
  endtask
  task automatic rc_pulse(input int k);
    i_recycle_src = fault_pkg::recycle_src_t'(3'h1 << k);
    cyc(3);
    i_recycle_src = '0;
    cyc(4);
  endtask
  task automatic t_recycle();
    int n;
    for (int k = 0; k < 3; k++) begin
      n = ons;
      rc_pulse(k);
      chk({o_supply_enable, o_ind_recycle}, 2'h1);
      cyc(RC - 10);
      chk(o_supply_enable, 1'b0);
      cyc(16);
      chk({o_supply_enable, 15'(ons - n)}, 16'h8001);
      cyc(PC);
    end
    rc_pulse(0);
    cyc(RC + 10);
    rc_pulse(0);
    chk({o_shutdown_fault, o_supply_enable}, 2'h2);
    $display("test recycle done");
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  // hang guard, several times the expected length
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    {i_refl_trip, i_over_temp, i_conv_error, i_fuse_open} = 4'h0;
    {i_local_reset, i_remote_reset, i_turn_on_cmd} = 3'h0;
    i_shutdown_src = '0;
    i_recycle_src = '0;
    i_kill_src = '0;
    i_rstn = 1'b0;
    cyc(5);
    i_rstn = 1'b1;
    cyc(1);
    chk({o_shutdown_fault, o_supply_enable, o_lower_req, o_amplifier_kill, o_ind_shutdown,
      o_ind_recycle, o_ind_refl_lower, o_ind_fuse}, 16'h0);
    i_fuse_open = 1'b1;
    cyc(6);
    chk(o_ind_fuse, 1'b0);
    i_fuse_open = 1'b0;
    t_shutdown();
    t_kill();
    t_refl();
    t_recycle();
    summarize();
  end
endmodule
